// file: design/rccs_top.sv
// relay command check sequencer: command outputs, resistance check, supervision and leds
`timescale 1ns/1ps
`include "rccs_regs.svh"

// How it works
// - check ensures exactly one interposing relay
// - checked flag selects one-and-a-half pole check
// - inside both limits releases, acknowledges positively
// - outside limits blocks output, flags fault
// - check starts after relay on and order
// - check relay connects measuring circuit
// - pass: drop check relay, then release
// - duration overrun resets all outputs
// - each output timed by its configured duration
// - coil voltage watched, only while check or release relay on
// - read back compared with commanded pattern
// - any supervision fault cancels command
// - self-tests at init and run, reported
// - four command outputs, one common return
// - limits compared in 10 ohm steps
// - red led on any fault
// - red led on relay supply failure
// - green led while release relay active
// - yellow led per active output
module rccs_top #(
  parameter int NOUT = 4,
  parameter int DW = 16,
  parameter int SETTLE_CYC = `RCCS_SETTLE_CYC,
  parameter int TICK_CYC = `RCCS_TICK_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [NOUT-1:0] command_output_relays,
  output logic check_relay,
  output logic release_relay,
  input wire logic [NOUT-1:0] readback_pins,
  input wire logic coil_voltage_ok_pin,
  input wire logic external_supply_voltage_ok_pin,
  input wire logic meas_valid_pin,
  input wire logic [DW-1:0] meas_value,
  output logic err_led,
  output logic supply_fail_led,
  output logic release_active_led,
  output logic [NOUT-1:0] output_active_leds
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  rccs_pkg::rccs_wb_req_t req;
  rccs_pkg::rccs_state_t state_q, state_d;
  rccs_pkg::rccs_leds_t leds_d;
  logic enable_q;
  logic selftest_q;
  logic [DW-1:0] lim_lo_q;
  logic [DW-1:0] lim_hi_q;
  logic [DW-1:0] meas_q;
  logic [5:0] fault_q;
  logic [NOUT-1:0] out_q;
  logic [NOUT-1:0] pend_sel_q;
  logic ack_pos_q;
  logic busy_q;
  logic [31:0] timer_q;
  logic [31:0] tick_q;
  logic [DW-1:0] dur_cnt_q [NOUT];
  logic [1:0] scan_q;
  logic [DW-1:0] dur_lim;
  logic [DW-1:0] dur_lim_q [NOUT];
  logic [NOUT-1:0] rb_s;
  logic cv_s;
  logic sup_fail_s;
  logic mv_s;
  logic init_test_q;
  logic [31:0] rb_wait_q;
  logic [NOUT-1:0] out_prev_q;
  logic [NOUT-1:0] dur_set_q;
  logic rd_ok_q;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  rccs_sync #(.WIDTH(NOUT + 3)) u_sync (
    .clk(clk),
    .reset(reset),
    .din({readback_pins, coil_voltage_ok_pin, ~external_supply_voltage_ok_pin, meas_valid_pin}),
    .dout({rb_s, cv_s, sup_fail_s, mv_s}) // supply sense inverted, reset reads as supply good
  );

  // ----------------------------------------
  // wishbone decode
  // ----------------------------------------
  assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i, stb: wb_stb_i, cyc: wb_cyc_i};
  wire acc = req.cyc && req.stb && !wb_ack_o;
  wire wr = acc && req.we && req.sel[0];
  wire [7:0] off = req.adr[7:0];
  wire wr_ctrl = wr && off == `RCCS_OFF_CTRL;
  wire wr_cmd = wr && off == `RCCS_OFF_CMD;
  wire wr_lo = wr && off == `RCCS_OFF_LIMLO;
  wire wr_hi = wr && off == `RCCS_OFF_LIMHI;
  wire wr_fault = wr && off == `RCCS_OFF_FAULT;
  wire wr_dur = wr && off[7:4] == 4'h2 && off[1:0] == 2'b00;
  wire [1:0] dur_idx = off[3:2];
  wire [NOUT-1:0] cmd_bits = req.dat[NOUT-1:0];
  wire cmd_go = wr_cmd && req.dat[`RCCS_CMD_GO];
  wire cmd_checked = req.dat[`RCCS_CMD_CHECKED];
  wire [15:0] wdat16 = req.dat[15:0];

  // ----------------------------------------
  // duration limit memory
  // ----------------------------------------
  rccs_durmem #(.DEPTH(NOUT), .AW(2), .DW(DW)) u_dur (
    .clk(clk),
    .we(wr_dur),
    .waddr(dur_idx),
    .wdata(wdat16),
    .raddr(scan_q),
    .rdata(dur_lim)
  );

  // ----------------------------------------
  // supervision terms
  // ----------------------------------------
  // exactly one output selected for a checked command
  wire one_hot = cmd_bits != '0 && (cmd_bits & (cmd_bits - 1'b1)) == '0;
  wire in_lim = meas_q >= lim_lo_q && meas_q <= lim_hi_q;
  wire meas_range = meas_value >= `RCCS_MEAS_MIN && meas_value <= `RCCS_MEAS_MAX;
  wire timer_done = timer_q == 32'h0000_0000;
  wire tick = tick_q == 32'h0000_0000;
  wire volt_fault = (check_relay || release_relay) && !cv_s;
  wire rb_settled = rb_wait_q == 32'h0000_0000 && out_prev_q == out_q; // relays had time to follow
  wire rb_fault = (rb_s != out_q) && rb_settled && state_q == rccs_pkg::RCCS_IDLE;
  wire supply_fault = sup_fail_s;
  logic [NOUT-1:0] dur_over;
  wire any_fault = volt_fault || rb_fault || (dur_over != '0) || supply_fault;
  wire selftest_fault = selftest_q && (rb_s != out_q);

  // per-output duration compare against its limit
  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : g_dur
      assign dur_over[g] = out_q[g] && dur_lim_q[g] != '0 && dur_cnt_q[g] >= dur_lim_q[g];
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          dur_cnt_q[g] <= '0;
          dur_lim_q[g] <= '0;
        end else begin
          if (scan_q == 2'(g + 1)) begin
            dur_lim_q[g] <= rd_ok_q ? dur_lim : '0; // read data lags the scan address by one
          end
          if (!out_q[g]) begin
            dur_cnt_q[g] <= '0;
          end else if (tick && dur_cnt_q[g] != '1) begin
            dur_cnt_q[g] <= dur_cnt_q[g] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // check sequencer
  // ----------------------------------------
  // one checked command at a time, release gated by pass
  always_comb begin
    state_d = state_q;
    case (state_q)
      rccs_pkg::RCCS_IDLE: begin
        if (cmd_go && cmd_checked && one_hot && enable_q && !busy_q) begin
          state_d = rccs_pkg::RCCS_CHECK;
        end
      end
      rccs_pkg::RCCS_CHECK: begin
        if (any_fault) begin
          state_d = rccs_pkg::RCCS_IDLE;
        end else if (timer_done) begin
          state_d = rccs_pkg::RCCS_MEASURE;
        end
      end
      rccs_pkg::RCCS_MEASURE: begin
        if (any_fault) begin
          state_d = rccs_pkg::RCCS_IDLE;
        end else if (mv_s && timer_done) begin
          state_d = rccs_pkg::RCCS_SWITCH;
        end
      end
      rccs_pkg::RCCS_SWITCH: begin
        if (!in_lim || any_fault) begin
          state_d = rccs_pkg::RCCS_IDLE;
        end else if (timer_done) begin
          state_d = rccs_pkg::RCCS_RELEASE;
        end
      end
      rccs_pkg::RCCS_RELEASE: begin
        if (any_fault || out_q == '0) begin
          state_d = rccs_pkg::RCCS_IDLE;
        end
      end
      default: begin
        state_d = rccs_pkg::RCCS_IDLE;
      end
    endcase
  end

  // state, timers and measurement capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= rccs_pkg::RCCS_IDLE;
      timer_q <= 32'h0000_0000;
      tick_q <= 32'h0000_0000;
      meas_q <= '0;
      scan_q <= 2'h0;
      rb_wait_q <= 32'h0000_0000;
      out_prev_q <= '0;
      dur_set_q <= '0;
      rd_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      scan_q <= scan_q + 2'h1;
      rd_ok_q <= dur_set_q[scan_q];
      dur_set_q <= wr_dur ? dur_set_q | (NOUT'(1) << dur_idx) : dur_set_q;
      out_prev_q <= out_q;
      rb_wait_q <= out_prev_q != out_q ? 32'(SETTLE_CYC) : rb_wait_q - 32'(rb_wait_q != 32'h0000_0000);
      tick_q <= tick ? 32'(TICK_CYC - 1) : tick_q - 32'h0000_0001;
      if (state_d != state_q) begin
        timer_q <= 32'(SETTLE_CYC);
      end else if (!timer_done) begin
        timer_q <= timer_q - 32'h0000_0001;
      end
      if (state_q == rccs_pkg::RCCS_MEASURE && mv_s) begin
        meas_q <= meas_range ? meas_value : '1;
      end
    end
  end

  // ----------------------------------------
  // outputs and relays
  // ----------------------------------------
  assign command_output_relays = out_q; // port follows the output register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q <= '0;
      pend_sel_q <= '0;
      check_relay <= 1'b0;
      release_relay <= 1'b0;
      busy_q <= 1'b0;
      ack_pos_q <= 1'b0;
    end else begin
      check_relay <= state_d == rccs_pkg::RCCS_CHECK || state_d == rccs_pkg::RCCS_MEASURE;
      release_relay <= state_d == rccs_pkg::RCCS_RELEASE;
      busy_q <= state_d != rccs_pkg::RCCS_IDLE;
      if (state_q == rccs_pkg::RCCS_SWITCH && state_d == rccs_pkg::RCCS_RELEASE) begin
        ack_pos_q <= 1'b1;
      end else if (cmd_go) begin
        ack_pos_q <= 1'b0;
      end
      if (any_fault || selftest_fault || !enable_q) begin
        out_q <= '0;
      end else if (state_q == rccs_pkg::RCCS_SWITCH && !in_lim) begin
        out_q <= '0;
      end else if (cmd_go && cmd_checked && state_q == rccs_pkg::RCCS_IDLE && one_hot) begin
        out_q <= cmd_bits;
        pend_sel_q <= cmd_bits;
      end else if (cmd_go && !cmd_checked && !busy_q) begin
        out_q <= cmd_bits;
      end else if (wr_cmd && !req.dat[`RCCS_CMD_GO]) begin
        out_q <= cmd_bits & out_q;
      end
    end
  end

  // ----------------------------------------
  // configuration and fault registers
  // ----------------------------------------
  // sticky faults: a new event beats a software clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enable_q <= 1'b0;
      selftest_q <= 1'b0;
      init_test_q <= 1'b1;
      lim_lo_q <= `RCCS_LIMLO_RESET;
      lim_hi_q <= `RCCS_LIMHI_RESET;
      fault_q <= '0;
    end else begin
      if (wr_ctrl) begin
        enable_q <= req.dat[`RCCS_CTRL_ENABLE];
      end
      selftest_q <= (wr_ctrl && req.dat[`RCCS_CTRL_SELFTEST]) || init_test_q;
      init_test_q <= 1'b0;
      if (wr_lo) begin
        lim_lo_q <= wdat16;
      end
      if (wr_hi) begin
        lim_hi_q <= wdat16;
      end
      fault_q <= (wr_fault ? fault_q & ~req.dat[5:0] : fault_q) | {
        supply_fault,
        selftest_fault,
        state_q == rccs_pkg::RCCS_SWITCH && !in_lim,
        rb_fault,
        volt_fault,
        dur_over != '0
      };
    end
  end

  // ----------------------------------------
  // read mux and bus answer
  // ----------------------------------------
  wire [31:0] rd_status = {24'h00_0000, ack_pos_q, busy_q, 2'h0, out_q};
  wire [31:0] rd_mux =
    off == `RCCS_OFF_CTRL ? {30'h0000_0000, selftest_q, enable_q} :
    off == `RCCS_OFF_CMD ? {28'h000_0000, pend_sel_q} :
    off == `RCCS_OFF_LIMLO ? {16'h0000, lim_lo_q} :
    off == `RCCS_OFF_LIMHI ? {16'h0000, lim_hi_q} :
    off == `RCCS_OFF_STATUS ? rd_status :
    off == `RCCS_OFF_FAULT ? {26'h000_0000, fault_q} :
    off == `RCCS_OFF_MEAS ? {16'h0000, meas_q} : 32'h0000_0000;

  // single-cycle ack, data registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= acc && !req.we ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  assign leds_d = '{fault: fault_q != '0 || any_fault, supply: supply_fault,
    release_on: release_relay, outputs: rb_s};
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      err_led <= 1'b0;
      supply_fail_led <= 1'b0;
      release_active_led <= 1'b0;
      output_active_leds <= '0;
    end else begin
      err_led <= leds_d.fault;
      supply_fail_led <= leds_d.supply;
      release_active_led <= leds_d.release_on;
      output_active_leds <= leds_d.outputs;
    end
  end
endmodule

// file: design/rccs_regs.svh
// register offsets, field positions, reset values and timing counts of the command check sequencer
`ifndef RCCS_REGS_SVH
`define RCCS_REGS_SVH
`define RCCS_OFF_CTRL 8'h00
`define RCCS_OFF_CMD 8'h04
`define RCCS_OFF_LIMLO 8'h08
`define RCCS_OFF_LIMHI 8'h0C
`define RCCS_OFF_STATUS 8'h10
`define RCCS_OFF_FAULT 8'h14
`define RCCS_OFF_MEAS 8'h18
`define RCCS_OFF_DUR0 8'h20
`define RCCS_CTRL_ENABLE 0
`define RCCS_CTRL_SELFTEST 1
`define RCCS_CMD_GO 8
`define RCCS_CMD_CHECKED 9
`define RCCS_FLT_DUR 0
`define RCCS_FLT_VOLT 1
`define RCCS_FLT_READBACK 2
`define RCCS_FLT_RES 3
`define RCCS_FLT_SELFTEST 4
`define RCCS_FLT_SUPPLY 5
`define RCCS_LIMLO_RESET 16'h000A
`define RCCS_LIMHI_RESET 16'h03E8
`define RCCS_MEAS_MIN 16'h000A
`define RCCS_MEAS_MAX 16'h03E8
`define RCCS_OHM_PER_LSB 10
`define RCCS_CLK_MHZ 200
`define RCCS_SETTLE_US 10
`define RCCS_SETTLE_CYC ((`RCCS_SETTLE_US * `RCCS_CLK_MHZ))
`define RCCS_TICK_US 1000
`define RCCS_TICK_CYC ((`RCCS_TICK_US * `RCCS_CLK_MHZ))
`endif

// file: design/rccs_pkg.sv
// types shared by the command check sequencer
package rccs_pkg;
  typedef enum logic [2:0] {
    RCCS_IDLE,
    RCCS_CHECK,
    RCCS_MEASURE,
    RCCS_SWITCH,
    RCCS_RELEASE
  } rccs_state_t;

  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic stb;
    logic cyc;
  } rccs_wb_req_t;

  typedef struct packed {
    logic fault;
    logic supply;
    logic release_on;
    logic [3:0] outputs;
  } rccs_leds_t;
endpackage

// file: design/rccs_sync.sv
// three-stage synchroniser for pin inputs, change taken when stages two and three agree
`timescale 1ns/1ps
module rccs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // per-bit chain and agreement filter
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          dout[i] <= 1'b0;
        end else begin
          s1_q[i] <= din[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            dout[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

// file: design/rccs_durmem.sv
// small memory of per-output duration limits, registered read
`timescale 1ns/1ps
module rccs_durmem #(
  parameter int DEPTH = 4,
  parameter int AW = 2,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // write port and registered read port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// file: testbench/rccs_chk.sv
// port assertions for the command check sequencer
`timescale 1ns/1ps
module rccs_chk #(
  parameter int NOUT = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [NOUT-1:0] command_output_relays,
  input wire logic check_relay,
  input wire logic release_relay,
  input wire logic [NOUT-1:0] readback_pins,
  input wire logic external_supply_voltage_ok_pin,
  input wire logic err_led,
  input wire logic supply_fail_led,
  input wire logic release_active_led,
  input wire logic [NOUT-1:0] output_active_leds
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // bus answers one cycle after the request
  a_bus_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_check_onehot: assert property ($rose(check_relay) |-> $onehot(command_output_relays))
    else $error("check without one output");
  a_no_overlap: assert property (!(check_relay && release_relay))
    else $error("check and release together");
  a_release_clean: assert property ($rose(release_relay) |-> !$past(release_relay) && $onehot(command_output_relays))
    else $error("release without single output");
  a_green_led: assert property ($rose(release_relay) |-> ##[0:2] release_active_led)
    else $error("green led missing");
  a_yellow_leds: assert property ($stable(readback_pins) [*6] |-> output_active_leds == readback_pins)
    else $error("yellow leds wrong");
  a_supply_led: assert property (!external_supply_voltage_ok_pin [*8] |-> supply_fail_led)
    else $error("supply led missing");
  a_supply_cancel: assert property (!external_supply_voltage_ok_pin [*8] |-> command_output_relays == '0)
    else $error("outputs kept on supply loss");
  a_red_led: assert property ($rose(supply_fail_led) |-> ##[0:2] err_led)
    else $error("red led missing");
  // main scenarios reached
  c_release: cover property ($rose(release_relay));
  c_check: cover property ($rose(check_relay));
  c_supply: cover property ($fell(external_supply_voltage_ok_pin));
endmodule

bind rccs_top rccs_chk #(.NOUT(NOUT)) chk_u (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .command_output_relays(command_output_relays), .check_relay(check_relay),
  .release_relay(release_relay), .readback_pins(readback_pins),
  .external_supply_voltage_ok_pin(external_supply_voltage_ok_pin), .err_led(err_led),
  .supply_fail_led(supply_fail_led), .release_active_led(release_active_led),
  .output_active_leds(output_active_leds));

// file: testbench/rccs_relay_model.sv
// interposing relays and measuring circuit on the far side
`timescale 1ns/1ps
module rccs_relay_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] command_output_relays,
  input wire logic check_relay,
  input wire logic [15:0] coil_res,
  input wire logic [3:0] meas_dly,
  output logic [3:0] readback_pins,
  output logic coil_voltage_ok_pin,
  output logic meas_valid_pin,
  output logic [15:0] meas_value
);
  // -----------
  // relay model
  // -----------
  logic [3:0] wait_q;
  assign coil_voltage_ok_pin = 1'b1;
  // contacts follow coils, measurement only while connected
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readback_pins <= 4'h0;
      wait_q <= 4'h0;
      meas_valid_pin <= 1'b0;
      meas_value <= 16'h5A5A;
    end else begin
      readback_pins <= command_output_relays;
      if (check_relay && wait_q >= meas_dly) begin
        meas_valid_pin <= 1'b1;
        meas_value <= coil_res;
      end else begin
        meas_valid_pin <= 1'b0;
        meas_value <= ~meas_value;
      end
      wait_q <= check_relay ? wait_q + ((wait_q == 4'hF) ? 4'h0 : 4'h1) : 4'h0;
    end
  end
endmodule

// file: testbench/rccs_top_tb.sv
// self-checking bench for the command check sequencer
`timescale 1ns/1ps
module rccs_top_tb;
  logic clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, check_relay, release_relay;
  logic coil_voltage_ok_pin, external_supply_voltage_ok_pin, meas_valid_pin;
  logic err_led, supply_fail_led, release_active_led;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] command_output_relays, readback_pins, output_active_leds, meas_dly;
  logic [15:0] meas_value, coil_res;
  int n_mismatch = 0;
  int checked = 0;
  // ------------
  // instances
  // ------------
  rccs_top #(.SETTLE_CYC(4), .TICK_CYC(10)) dut_u (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .command_output_relays(command_output_relays),
    .check_relay(check_relay), .release_relay(release_relay), .readback_pins(readback_pins),
    .coil_voltage_ok_pin(coil_voltage_ok_pin), .external_supply_voltage_ok_pin(external_supply_voltage_ok_pin),
    .meas_valid_pin(meas_valid_pin), .meas_value(meas_value), .err_led(err_led),
    .supply_fail_led(supply_fail_led), .release_active_led(release_active_led),
    .output_active_leds(output_active_leds));
  rccs_relay_model model_u (.clk(clk), .reset(reset), .command_output_relays(command_output_relays),
    .check_relay(check_relay), .coil_res(coil_res), .meas_dly(meas_dly), .readback_pins(readback_pins),
    .coil_voltage_ok_pin(coil_voltage_ok_pin), .meas_valid_pin(meas_valid_pin), .meas_value(meas_value));
  // ------------
  // tasks
  // ------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {24'h000000, a};
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_mismatch++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    checked++;
    if (v !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic t_reset;
    logic [31:0] q;
    wb(1'b0, 8'h08, 32'h0, q);
    chk("lower limit", 32'h0000000A, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk("upper limit", 32'h000003E8, q);
    wb(1'b0, 8'h3C, 32'h0, q);
    chk("unmapped", 32'h0, q);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("faults", 32'h0, q);
    chk("outputs", 32'h0, {28'h0, command_output_relays});
  endtask
  task automatic t_open;
    logic [31:0] q;
    wr(8'h04, 32'h00000105);
    repeat (8) @(posedge clk);
    chk("outputs", 32'h5, {28'h0, command_output_relays});
    chk("check relay", 32'h0, {31'h0, check_relay});
    chk("yellow leds", 32'h5, {28'h0, output_active_leds});
    wb(1'b0, 8'h10, 32'h0, q);
    chk("status", 32'h5, q & 32'h0000004F);
    wr(8'h04, 32'h0);
  endtask
  task automatic t_check(input logic [15:0] res, input logic pass, input logic [3:0] dly);
    logic [31:0] q;
    int n;
    n = 0;
    coil_res <= res;
    meas_dly <= dly;
    wr(8'h04, 32'h00000304);
    while (release_relay !== 1'b1 && command_output_relays !== 4'h0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) n_mismatch++;
    chk("release", {31'h0, pass}, {31'h0, release_relay});
    chk("outputs", pass ? 32'h4 : 32'h0, {28'h0, command_output_relays});
    chk("check relay", 32'h0, {31'h0, check_relay});
    wb(1'b0, 8'h10, 32'h0, q);
    chk("positive ack", {31'h0, pass}, {31'h0, q[7]});
    wb(1'b0, 8'h14, 32'h0, q);
    chk("resistance fault", {31'h0, !pass}, {31'h0, q[3]});
    chk("green led", {31'h0, pass}, {31'h0, release_active_led});
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0000003F);
  endtask
  task automatic t_refuse;
    wr(8'h04, 32'h00000306);
    repeat (6) @(posedge clk);
    chk("outputs", 32'h0, {28'h0, command_output_relays});
    chk("check relay", 32'h0, {31'h0, check_relay});
  endtask
  task automatic t_duration;
    logic [31:0] q;
    wr(8'h20, 32'h00000002);
    wr(8'h04, 32'h00000101);
    repeat (5) @(posedge clk);
    chk("timed output", 32'h1, {28'h0, command_output_relays});
    repeat (45) @(posedge clk);
    chk("timed output", 32'h0, {28'h0, command_output_relays});
    wb(1'b0, 8'h14, 32'h0, q);
    chk("duration fault", 32'h1, {31'h0, q[0]});
    wr(8'h20, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0000003F);
  endtask
  task automatic t_supply;
    logic [31:0] q;
    wr(8'h04, 32'h0000010F);
    external_supply_voltage_ok_pin <= 1'b0;
    repeat (12) @(posedge clk);
    chk("outputs", 32'h0, {28'h0, command_output_relays});
    chk("supply led", 32'h1, {31'h0, supply_fail_led});
    chk("red led", 32'h1, {31'h0, err_led});
    wb(1'b0, 8'h14, 32'h0, q);
    chk("supply fault", 32'h1, {31'h0, q[5]});
    external_supply_voltage_ok_pin <= 1'b1;
    wr(8'h04, 32'h0);
  endtask
  task automatic results;
    if (n_mismatch == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ------------
  // sequence
  // ------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results;
  end
  initial begin
    logic [31:0] q;
    reset = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    external_supply_voltage_ok_pin = 1'b1;
    coil_res = 16'h0;
    meas_dly = 4'h2;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset;
    wr(8'h08, 32'h00000014);
    wr(8'h0C, 32'h0000001E);
    wr(8'h00, 32'h00000003);
    repeat (10) @(posedge clk);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("selftest fault", 32'h0, {31'h0, q[4]});
    t_open;
    t_check(16'h0019, 1'b1, 4'hE);
    t_check(16'h001F, 1'b0, 4'h2);
    t_check(16'h0013, 1'b0, 4'h2);
    t_refuse;
    t_duration;
    t_supply;
    results;
  end
endmodule
